// *** mips_fifo.sv ***
// Purpose: Dual clock FIFO carrying commands to the link domain
// Assumes: Gray pointers, two-flop synchronisers each way
// Notes:   Depth must be a power of two
module mips_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             wr_clk,
    input  wire logic             wr_rst,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_clk,
    input  wire logic             rd_rst,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];          // Storage
    logic [AW:0]      wptr, rptr;           // Binary pointers
    logic [AW:0]      wgray, rgray;         // Gray pointers
    logic [AW:0]      rg_s1, rg_s2;         // Read pointer into write side
    logic [AW:0]      wg_s1, wg_s2;         // Write pointer into read side

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    assign wgray = to_gray(wptr);
    assign rgray = to_gray(rptr);
    // Full when gray pointers differ only in top two bits
    assign wr_ready = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
    assign rd_valid = (rgray != wg_s2);
    assign rd_data  = mem[rptr[AW-1:0]];

    // Write side
    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            wptr <= '0;
        end else if (wr_valid && wr_ready) begin
            mem[wptr[AW-1:0]] <= wr_data;
            wptr <= wptr + 1'b1;
        end
    end
    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            rg_s1 <= '0;
            rg_s2 <= '0;
        end else begin
            rg_s1 <= rgray;
            rg_s2 <= rg_s1;
        end
    end

    // Read side
    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            rptr <= '0;
        end else if (rd_valid && rd_ready) begin
            rptr <= rptr + 1'b1;
        end
    end
    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            wg_s1 <= '0;
            wg_s2 <= '0;
        end else begin
            wg_s1 <= wgray;
            wg_s2 <= wg_s1;
        end
    end
endmodule // mips_fifo

// *** mips_pkg.sv ***
// Purpose: Shared constants and types for the image programming sequencer
// Assumes: 200 MHz system clock, separate link clock for the serial pins
// Notes:   Image records arrive as hex byte address plus data byte
package mips_pkg;
    // Hex-file byte address windows
    localparam logic [15:0] FLASH_LO    = 16'h0000;
    localparam logic [15:0] FLASH_HI    = 16'h07FD;
    localparam logic [15:0] OSCCAL_LO   = 16'h07FE;
    localparam logic [15:0] OSCCAL_HI   = 16'h07FF;
    localparam logic [15:0] ID_LO       = 16'h4000;
    localparam logic [15:0] ID_HI       = 16'h4007;
    localparam logic [15:0] CFG_LO      = 16'h400E;
    localparam logic [15:0] CFG_HI      = 16'h400F;
    localparam logic [15:0] EE_LO       = 16'h4200;
    localparam logic [15:0] EE_HI       = 16'h42FF;
    // Target word locations and field layouts
    localparam logic [9:0]  CAL_WORD    = 10'h3FF;
    localparam logic [13:0] RETURN_LITERAL_INSTRUCTION_OP    = 14'h3400;
    localparam logic [13:0] CFG_USER_M  = 14'h01FF;
    localparam logic [13:0] CFG_BG_M    = 14'h3000;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    // Power switching delay
    localparam int          PWR_DLY_US  = 1000;
    localparam int          CLK_MHZ     = 200;
    localparam int          PWR_DLY_CYC = PWR_DLY_US * CLK_MHZ;
    localparam int          FIFO_DEPTH  = 8;
    // Hold-off so a just-queued frame is seen busy by the link
    localparam int          DRAIN_CYC   = 32;

    // Target areas
    typedef enum logic [2:0] {
        MIPS_AREA_NONE, MIPS_AREA_FLASH, MIPS_AREA_ID,
        MIPS_AREA_CFG, MIPS_AREA_EE, MIPS_AREA_CALWORD
    } mips_area_type;

    // One incoming image byte
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } mips_rec_type;

    // One word write sent to the link
    typedef struct packed {
        mips_area_type area;
        logic [9:0]    waddr;
        logic [13:0]   wdata;
    } mips_cmd_type;
    localparam int CMD_W = $bits(mips_cmd_type);
endpackage : mips_pkg

// *** mips_seq.sv ***
// Purpose: Routes image bytes to target areas and drives the serial link
// Assumes: Image bytes arrive in ascending order, low byte before high
// Notes:   Serial command encodings are out of scope; words shift LSB first
// Operation
// - Hex 0x0000-0x07FD go to flash words
// - Drop image bytes at 0x07FE and 0x07FF
// - Hex 0x4000-0x4007 become four ID words
// - Config takes bits 0-8, band-gap ignored
// - EEPROM takes every second byte, 128 bytes
// - Rewrite calibration literal at word 0x3FF
// - Restore captured band-gap bits after programming
// - Program only areas present in image; config is always written for band-gap, cal word also with preserve_cal
// - Override replaces image configuration bits
// - Update only present EEPROM bytes, no fill
// - Keep last flash cell high byte
// - Recovery drives clock on serial clock output
// - Never set the reset-disable fuse
// - High voltage first, then target supply
// - Power switching delay of 1 ms
// - Link uses clear, data, clock, ground
module mips_seq
    import mips_pkg::*;
#(
    parameter int PWR_DELAY = mips_pkg::PWR_DLY_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   link_clk,
    input  wire logic                   link_rst,
    input  wire mips_pkg::mips_rec_type rec,
    input  wire logic                   rec_valid,
    output logic                        rec_ready,
    input  wire logic                   image_done,
    input  wire logic                   start,
    input  wire logic                   recover,
    input  wire logic                   cfg_override,
    input  wire logic [8:0]             cfg_user,
    input  wire logic [7:0]             osc_cal,
    input  wire logic [1:0]             bg_cal,
    input  wire logic                   preserve_cal,
    input  wire logic                   power_switch,
    output logic                        busy,
    output logic [3:0]                  area_seen,
    output logic                        high_voltage_clear_out,
    output logic                        switched_supply_out,
    output logic                        programmer_serial_clock,
    output logic                        programmer_serial_data,
    output logic                        programmer_serial_data_oe,
    input  wire logic                   programmer_serial_data_in,
    output logic                        reset_disable_fuse
);
    import mips_pkg::*;

    typedef enum {
        S_IDLE, S_HV, S_PWR, S_RUN, S_CAL, S_BG, S_DRAIN, S_RECOV
    } mips_state_type;

    mips_state_type   state;            // Sequencer state
    logic [31:0]      dly;              // Power delay counter
    logic [7:0]       lo_byte;          // Pending low byte
    logic             lo_have;          // Low byte held
    logic [13:0]      cfg_word;         // Config word; only reset writes it
    mips_cmd_type     cmd;              // Command to FIFO
    logic             cmd_valid;        // Command pending
    logic             cmd_ready;        // FIFO can take it
    mips_area_type    area;             // Area of incoming byte
    logic             rec_take;         // Byte consumed
    logic             stop_s1, stop_s2; // Recovery clear into link
    logic             clr_s1, clr_s2;   // Link busy back into system
    logic             recov_on;         // Registered recovery request
    logic             l_busy;           // Frame queued or shifting
    logic             l_valid, l_ready; // Link side of the FIFO
    mips_cmd_type     l_cmd;            // Command at the FIFO head

    // Address window decode, shared by routing and bookkeeping
    function automatic mips_area_type decode(input logic [15:0] a);
        if (a <= FLASH_HI)                  return MIPS_AREA_FLASH;
        if (a >= OSCCAL_LO && a <= OSCCAL_HI) return MIPS_AREA_NONE;
        if (a >= ID_LO && a <= ID_HI)       return MIPS_AREA_ID;
        if (a >= CFG_LO && a <= CFG_HI)     return MIPS_AREA_CFG;
        if (a >= EE_LO && a <= EE_HI)       return MIPS_AREA_EE;
        return MIPS_AREA_NONE;
    endfunction

    assign area     = decode(rec.addr);
    // Stall when a word is waiting for FIFO room
    assign rec_ready = (state == S_RUN) && !(cmd_valid && !cmd_ready);
    assign rec_take  = rec_valid && rec_ready;
    assign busy      = (state != S_IDLE);
    // The fuse is never requested by this sequencer
    assign reset_disable_fuse = 1'b0;

    // Main sequence; supply only after high voltage is up
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= S_IDLE;
            dly   <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    dly <= '0;
                    if (recover) begin
                        state <= S_RECOV;
                    end else if (start) begin
                        state <= S_HV;
                    end
                end
                S_HV: begin
                    // Let clear reach high voltage first
                    dly <= dly + 1;
                    if (!power_switch || dly == 32'(PWR_DELAY - 1)) begin
                        state <= S_PWR;
                    end
                end
                S_PWR:  state <= S_RUN;
                S_RUN: begin
                    if (image_done && !lo_have && !cmd_valid) begin
                        state <= S_CAL;
                    end
                end
                S_CAL: if (!cmd_valid) state <= S_BG;
                S_BG: begin
                    dly <= '0;
                    // Leave only once the band-gap word is queued
                    if (!cmd_valid && area_seen[2]) begin
                        state <= S_DRAIN;
                    end
                end
                S_DRAIN: begin
                    // Clear line must hold until the last frame is out
                    dly <= dly + 1;
                    if (dly >= 32'(DRAIN_CYC) && !clr_s2) begin
                        state <= S_IDLE;
                    end
                end
                S_RECOV: if (!recover) state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Target supply follows high voltage, never precedes it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            high_voltage_clear_out <= 1'b0;
            switched_supply_out    <= 1'b0;
        end else begin
            high_voltage_clear_out <= (state == S_HV) || (state == S_PWR)
                || (state == S_RUN) || (state == S_CAL) || (state == S_BG)
                || (state == S_DRAIN);
            switched_supply_out <= power_switch && ((state == S_PWR)
                || (state == S_RUN) || (state == S_CAL)
                || (state == S_BG) || (state == S_DRAIN));
        end
    end

    // Recovery flag registered before it crosses; link busy comes back
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            recov_on <= 1'b0;
            clr_s1   <= 1'b0;
            clr_s2   <= 1'b0;
        end else begin
            recov_on <= (state == S_RECOV);
            clr_s1   <= l_busy;
            clr_s2   <= clr_s1;
        end
    end

    // Byte pairing and command build
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lo_byte   <= '0;
            lo_have   <= 1'b0;
            cmd       <= '0;
            cmd_valid <= 1'b0;
            cfg_word  <= '0;
            area_seen <= '0;
        end else begin
            if (cmd_valid && cmd_ready) begin
                cmd_valid <= 1'b0;
            end
            if (state == S_IDLE) begin
                lo_have   <= 1'b0;
            end
            // Areas stay readable after a run, cleared by the next start
            if (state == S_IDLE && start) begin
                area_seen <= '0;
            end
            if (rec_take) begin
                if (area == MIPS_AREA_EE) begin
                    // Odd bytes are padding; even bytes are data
                    if (!rec.addr[0]) begin
                        cmd.area  <= MIPS_AREA_EE;
                        cmd.waddr <= {3'b000, rec.addr[7:1]};
                        cmd.wdata <= {6'h00, rec.data};
                        cmd_valid <= 1'b1;
                        area_seen[3] <= 1'b1;
                    end
                end else if (area != MIPS_AREA_NONE) begin
                    if (!rec.addr[0]) begin
                        lo_byte <= rec.data;
                        lo_have <= 1'b1;
                    end else begin
                        lo_have   <= 1'b0;
                        cmd.area  <= area;
                        cmd.waddr <= rec.addr[10:1];
                        cmd_valid <= 1'b1;
                        case (area)
                            MIPS_AREA_FLASH: begin
                                cmd.wdata <= {rec.data[5:0], lo_byte};
                                area_seen[0] <= 1'b1;
                            end
                            MIPS_AREA_ID: begin
                                cmd.wdata <= {rec.data[5:0], lo_byte};
                                area_seen[1] <= 1'b1;
                            end
                            MIPS_AREA_CFG: begin
                                // User bits only, band-gap from capture
                                cmd.wdata <= cfg_override
                                    ? {bg_cal, 3'b000, cfg_user}
                                    : ({rec.data[5:0], lo_byte}
                                       & CFG_USER_M)
                                      | {bg_cal, 12'h000};
                                area_seen[2] <= 1'b1;
                            end
                            default: cmd.wdata <= '0;
                        endcase
                    end
                end
            end else if (state == S_CAL && !cmd_valid) begin
                // Calibration literal rewritten at the last word
                cmd.area  <= MIPS_AREA_CALWORD;
                cmd.waddr <= CAL_WORD;
                cmd.wdata <= RETURN_LITERAL_INSTRUCTION_OP | {6'h00, osc_cal};
                cmd_valid <= preserve_cal || area_seen[0];
            end else if (state == S_BG && !cmd_valid && !area_seen[2]) begin
                // Band-gap bits put back even without image config
                cmd.area  <= MIPS_AREA_CFG;
                cmd.waddr <= CFG_LO[10:1];
                cmd.wdata <= (cfg_override ? {5'h00, cfg_user} : '0)
                             | {bg_cal, 12'h000};
                cmd_valid <= 1'b1;
                area_seen[2] <= 1'b1;
            end
        end
    end

    // Cross commands into the link domain
    mips_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clk   (sys_clk),
        .wr_rst   (rst),
        .wr_valid (cmd_valid),
        .wr_ready (cmd_ready),
        .wr_data  (cmd),
        .rd_clk   (link_clk),
        .rd_rst   (link_rst),
        .rd_valid (l_valid),
        .rd_ready (l_ready),
        .rd_data  (l_cmd)
    );

    // Link domain shifter: one bit per two link clocks
    logic [4:0]   bitcnt;     // Bits left
    logic [26:0]  shreg;      // Address and data frame
    logic         sclk;       // Shift clock level

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
            l_busy  <= 1'b0;
        end else begin
            stop_s1 <= recov_on;
            stop_s2 <= stop_s1;
            l_busy  <= l_valid || (bitcnt != '0);
        end
    end

    assign l_ready = (bitcnt == '0);
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            bitcnt <= '0;
            shreg  <= '0;
            sclk   <= 1'b0;
        end else if (bitcnt != '0) begin
            sclk <= ~sclk;
            if (sclk) begin
                shreg  <= shreg >> 1;
                bitcnt <= bitcnt - 1'b1;
            end
        end else if (l_valid) begin
            shreg  <= {l_cmd.area, l_cmd.waddr, l_cmd.wdata};
            bitcnt <= 5'(CMD_W);
            sclk   <= 1'b0;
        end else begin
            // Free running clock for crystal recovery
            sclk <= stop_s2 ? ~sclk : 1'b0;
        end
    end

    // Link pins: clear, data, clock plus ground
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            programmer_serial_clock   <= 1'b0;
            programmer_serial_data    <= 1'b0;
            programmer_serial_data_oe <= 1'b0;
        end else begin
            programmer_serial_clock   <= sclk;
            programmer_serial_data    <= shreg[0];
            programmer_serial_data_oe <= (bitcnt != '0);
        end
    end

    // Supply never rises while high voltage is off
    supply_order_a: assert property (@(posedge sys_clk) disable iff (rst)
        switched_supply_out |-> high_voltage_clear_out)
        else $error("supply on without high voltage");
    cal_word_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_valid && cmd.area == MIPS_AREA_CALWORD) |->
        cmd.waddr == CAL_WORD && cmd.wdata[13:8] == RETURN_LITERAL_INSTRUCTION_OP[13:8])
        else $error("calibration word malformed");
    fuse_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        !reset_disable_fuse)
        else $error("reset disable requested");
    osc_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rec_take && rec.addr >= OSCCAL_LO && rec.addr <= OSCCAL_HI)
        |=> !$rose(cmd_valid))
        else $error("calibration bytes written");
    cfg_bg_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_valid && cmd.area == MIPS_AREA_CFG) |->
        cmd.wdata[13:12] == bg_cal && cmd.wdata[11:9] == 3'b000)
        else $error("config band gap wrong");
    ee_odd_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rec_take && area == MIPS_AREA_EE && rec.addr[0] && !cmd_valid)
        |=> !cmd_valid)
        else $error("padding byte written");
    pwr_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == S_HV && power_switch) [*8] |-> !switched_supply_out)
        else $error("supply before delay");
    // A frame still on the link keeps the clear line up
    hv_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        clr_s2 |-> high_voltage_clear_out)
        else $error("clear line dropped during frame");
endmodule // mips_seq

// *** mips_target_model.sv ***
// Purpose: Behavioural target seen through its serial programming pins
// Assumes: Frames of CMD_W bits, LSB first, sampled on rising clock
// Notes:   Clock edges with the data driver off count as recovery clock
module mips_target_model (
    input  wire logic programmer_serial_clock,
    input  wire logic programmer_serial_data,
    input  wire logic programmer_serial_data_oe,
    input  wire logic high_voltage_clear_out,
    input  wire logic switched_supply_out,
    output logic      programmer_serial_data_in
);
    import mips_pkg::*;

    mips_cmd_type     frames[$];  // Received word writes
    logic [CMD_W-1:0] shreg;      // Incoming shift register
    int               nbits;      // Bits of current frame
    int               free_edges; // Clock edges outside frames
    logic             last_bit;   // Last level driven on data

    initial begin
        nbits = 0;
        free_edges = 0;
        last_bit = 1'b0;
        shreg = '0;
    end

    // Shift in frames; only in programming mode with clear line high
    always @(posedge programmer_serial_clock) begin
        if (programmer_serial_data_oe && high_voltage_clear_out) begin
            shreg = {programmer_serial_data, shreg[CMD_W-1:1]};
            nbits++;
            if (nbits == CMD_W) begin
                frames.push_back(mips_cmd_type'(shreg));
                nbits = 0;
            end
        end else begin
            // Free running clock feeds the crystal input
            free_edges++;
            nbits = 0;
        end
    end

    // Remember what the programmer last drove
    always @* begin
        if (programmer_serial_data_oe) begin
            last_bit = programmer_serial_data;
        end
    end

    // Released line shows the inverse, so a stale value never matches
    assign programmer_serial_data_in = programmer_serial_data_oe ?
        programmer_serial_data : ~last_bit;
endmodule // mips_target_model

// *** tb.sv ***
// Purpose: Self-checking bench for the image programming sequencer
// Assumes: Byte stream handshake, link frames decoded by target model
// Notes:   Power delay shortened to PWR_SIM cycles
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mips_pkg::*;

    localparam int PWR_SIM = 20; // Short power delay
    // Image bytes {addr, data}; first 12 for run one, rest run two
    localparam logic [23:0] IMG [18] = '{
        24'h000034, 24'h0001FF, 24'h07FC12, 24'h07FD2B, 24'h07FE55,
        24'h07FF34, 24'h400644, 24'h400700, 24'h400EA5, 24'h400F31,
        24'h42045A, 24'h420500, 24'h400E00, 24'h400F3F, 24'h420011,
        24'h420100, 24'h421022, 24'h421100};

    logic sys_clk = 1'b0, rst = 1'b1, link_clk = 1'b0, link_rst = 1'b1;
    mips_rec_type rec = '0;
    logic rec_valid = 0, image_done = 0, start = 0, recover = 0;
    logic cfg_override = 0, preserve_cal = 0, power_switch = 0;
    logic [8:0]  cfg_user = '0;
    logic [7:0]  osc_cal = 8'h96;
    logic [1:0]  bg_cal = 2'b10;
    logic rec_ready, busy, hv, sup, sck, sdo, sdo_oe, sdi, fuse;
    logic [3:0]  area_seen;
    logic        sup_q = 1'b0;   // Supply one cycle ago
    int          hv_cyc = 0;     // Cycles since clear line rose
    int          n_errors = 0;
    int          checks_done = 0;

    // System clock 200 MHz
    always #2.5 sys_clk = ~sys_clk;
    // Link clock 12 ns, offset so edges never line up
    initial begin
        #1.7;
        forever #6 link_clk = ~link_clk;
    end
    // Link reset follows system reset in its own domain
    always @(posedge link_clk) link_rst <= rst;

    mips_seq #(.PWR_DELAY(PWR_SIM)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .link_rst(link_rst), .rec(rec), .rec_valid(rec_valid),
        .rec_ready(rec_ready), .image_done(image_done), .start(start),
        .recover(recover), .cfg_override(cfg_override),
        .cfg_user(cfg_user), .osc_cal(osc_cal), .bg_cal(bg_cal),
        .preserve_cal(preserve_cal), .power_switch(power_switch),
        .busy(busy), .area_seen(area_seen), .high_voltage_clear_out(hv),
        .switched_supply_out(sup), .programmer_serial_clock(sck),
        .programmer_serial_data(sdo), .programmer_serial_data_oe(sdo_oe),
        .programmer_serial_data_in(sdi), .reset_disable_fuse(fuse));

    mips_target_model tgt_u (
        .programmer_serial_clock(sck), .programmer_serial_data(sdo),
        .programmer_serial_data_oe(sdo_oe), .high_voltage_clear_out(hv),
        .switched_supply_out(sup), .programmer_serial_data_in(sdi));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Clear line age, and supply may only rise after the delay
    always @(posedge sys_clk) begin
        hv_cyc <= hv ? hv_cyc + 1 : 0;
        sup_q <= sup;
        if (sup && !sup_q) begin
            check("clear before supply", hv, 1'b1);
            if (power_switch) check("power delay", hv_cyc >= PWR_SIM, 1);
        end
    end

    // Send image bytes lo to hi, each held until taken
    task automatic send_img(input int lo, input int hi);
        int n;
        for (int i = lo; i <= hi; i++) begin
            @(posedge sys_clk);
            rec <= mips_rec_type'(IMG[i]);
            rec_valid <= 1'b1;
            n = 0;
            @(posedge sys_clk);
            while (rec_ready !== 1'b1 && n < 2000) begin
                @(posedge sys_clk);
                n++;
            end
            rec_valid <= 1'b0;
        end
    endtask

    // Start, stream, finish image, wait for n frames in total
    task automatic run(input int lo, input int hi, input int n);
        int k;
        @(posedge sys_clk) start <= 1'b1;
        @(posedge sys_clk) start <= 1'b0;
        send_img(lo, hi);
        @(posedge sys_clk) image_done <= 1'b1;
        k = 0;
        while (tgt_u.frames.size() < n && k < 6000) begin
            @(posedge sys_clk);
            k++;
        end
        while (busy !== 1'b0 && k < 6000) begin
            @(posedge sys_clk);
            k++;
        end
        image_done <= 1'b0;
        // Quiet spell: nothing beyond the expected frames may follow
        repeat (400) @(posedge sys_clk);
        check("frame count", tgt_u.frames.size(), n);
    endtask

    task automatic chk_fr(input int i, input logic [2:0] a,
                          input logic [9:0] am, input logic [9:0] wa,
                          input logic [13:0] dm, input logic [13:0] wd);
        mips_cmd_type f;
        f = tgt_u.frames[i];
        check("frame area", f.area, a);
        check("frame address", f.waddr & am, wa);
        check("frame data", f.wdata & dm, wd);
    endtask

    // Hang guard, well past the ~2600 cycles the run needs
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check("clear idle", hv, 1'b0);
        check("supply idle", sup, 1'b0);
        check("busy idle", busy, 1'b0);
        check("fuse", fuse, 1'b0);
        $display("test reset done");

        // Full image with switched power and bytes to drop
        power_switch <= 1'b1;
        run(0, 11, 6);
        chk_fr(0, MIPS_AREA_FLASH, 10'h3FF, 10'h000, 14'h3FFF, 14'h3F34);
        chk_fr(1, MIPS_AREA_FLASH, 10'h3FF, 10'h3FE, 14'h3FFF, 14'h2B12);
        chk_fr(2, MIPS_AREA_ID, 10'h3FF, 10'h003, 14'h3FFF, 14'h0044);
        chk_fr(3, MIPS_AREA_CFG, 10'h000, 10'h000, 14'h31FF, 14'h21A5);
        chk_fr(4, MIPS_AREA_EE, 10'h07F, 10'h002, 14'h00FF, 14'h005A);
        chk_fr(5, MIPS_AREA_CALWORD, 10'h3FF, 10'h3FF, 14'h3FFF, 14'h3496);
        check("areas one", area_seen, 4'b1111);
        check("fuse", fuse, 1'b0);
        $display("test full image done");

        // Config override, sparse EEPROM, no flash, keep calibration
        power_switch <= 1'b0;
        preserve_cal <= 1'b1;
        cfg_override <= 1'b1;
        cfg_user <= 9'h0C3;
        bg_cal <= 2'b01;
        run(12, 17, 10);
        chk_fr(6, MIPS_AREA_CFG, 10'h000, 10'h000, 14'h31FF, 14'h10C3);
        chk_fr(7, MIPS_AREA_EE, 10'h07F, 10'h000, 14'h00FF, 14'h0011);
        chk_fr(8, MIPS_AREA_EE, 10'h07F, 10'h008, 14'h00FF, 14'h0022);
        chk_fr(9, MIPS_AREA_CALWORD, 10'h3FF, 10'h3FF, 14'h3FFF, 14'h3496);
        check("areas two", area_seen, 4'b1100);
        $display("test override image done");

        // Recovery clock with no frames sent
        begin
            int e0;
            e0 = tgt_u.free_edges;
            @(posedge sys_clk) recover <= 1'b1;
            repeat (300) @(posedge sys_clk);
            check("recovery clock", tgt_u.free_edges - e0 >= 10, 1);
            check("recovery data off", sdo_oe, 1'b0);
            recover <= 1'b0;
            repeat (100) @(posedge sys_clk);
            check("recovery frames", tgt_u.frames.size(), 10);
            check("fuse", fuse, 1'b0);
        end
        $display("test recovery done");
        finish_test();
    end
endmodule // tb
